/* File: pcrb_pkg.sv */
// Summary of operation
// - Register space is paged by page select.
// - Page select holds eight bits, code equals page.
// - Writing one to reset bit restores defaults.
// - Software reset bit clears itself.
// - Channel enables reset to CC hex.
// - Converter configs reset to C9 and 80.
// - Output pair configs reset to 20 hex.
// - Device state one reads 80, zero reads 0.
// - Clock fault and ratio registers reset zero.
// - Signal processing config resets to 18 hex.
package pcrb_pkg;

  // ****************************************************************
  // Register indices, byte address is four times the index.
  // ****************************************************************
  localparam logic [7:0] IDX_PAGE = 8'h00;
  localparam logic [7:0] IDX_SRST = 8'h01;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h50;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'h51;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h52;
  localparam logic [7:0] PAGE_ZERO = 8'h00;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam int SRST_BIT = 0;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] IRQ_RESET = 8'h00;

  // ****************************************************************
  // Page zero register table.
  // ****************************************************************
  localparam int NUM_REGS = 30;
  localparam int NUM_EVENTS = 8;
  localparam logic [7:0] CELL_INDEX [NUM_REGS] = '{
    8'h3C, 8'h3D, 8'h3E, 8'h3F, 8'h40, 8'h41, 8'h42, 8'h43, 8'h4F, 8'h64,
    8'h65, 8'h66, 8'h67, 8'h68, 8'h69, 8'h6A, 8'h6B, 8'h6C, 8'h6D, 8'h6E,
    8'h6F, 8'h70, 8'h71, 8'h73, 8'h76, 8'h77, 8'h78, 8'h79, 8'h7A, 8'h7E};
  localparam logic [7:0] CELL_RESET [NUM_REGS] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h50, 8'h00, 8'h20,
    8'h20, 8'h20, 8'hC9, 8'h80, 8'hC9, 8'h80, 8'h20, 8'h20, 8'h20, 8'hC9,
    8'h80, 8'hC9, 8'h80, 8'h18, 8'hCC, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
  // Event slot of each read-only register, or -1 when software writes it.
  localparam int CELL_EVENT [NUM_REGS] = '{
    0, 1, 2, 3, 4, 5, -1, -1, -1, -1,
    -1, -1, -1, -1, -1, -1, -1, -1, -1, -1,
    -1, -1, -1, -1, -1, -1, -1, 6, 7, -1};
  localparam int SLOT_FAULT0 = 0;
  localparam int SLOT_RATIO3 = 5;
  localparam int SLOT_OUT1_0 = 9;
  localparam int SLOT_CH1A_0 = 12;
  localparam int SLOT_CH1A_1 = 13;
  localparam int SLOT_SPROC = 23;
  localparam int SLOT_CHANNEL_ENABLES = 24;
  localparam int SLOT_STATE0 = 27;
  localparam int SLOT_STATE1 = 28;

  // ****************************************************************
  // Types.
  // ****************************************************************
  typedef enum {
    KIND_NONE, KIND_PAGE, KIND_SRST, KIND_CELL,
    KIND_IRQ_STATUS, KIND_IRQ_CLEAR, KIND_IRQ_ENABLE
  } pcrb_kind_t;

  typedef struct packed {
    pcrb_kind_t kind;
    logic [4:0] slot;
  } pcrb_decode_t;

  typedef struct packed {
    logic [1:0][7:0] device_state;
    logic [3:0][7:0] ratio_detect;
    logic [1:0][7:0] clock_fault;
  } pcrb_events_t;

endpackage

/* File: pcrb_reg_cell.sv */
module pcrb_reg_cell
  import pcrb_pkg::*;
#(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter bit WRITABLE = 1'b1
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic soft_reset,
  input wire logic write_en,
  input wire logic [7:0] write_data,
  input wire logic [7:0] event_in,
  output logic [7:0] value
);

  // ****************************************************************
  // One register byte, writable or sticky read-only.
  // ****************************************************************
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      value <= RESET_VALUE;
    end
    else if (soft_reset)
    begin
      value <= RESET_VALUE;
    end
    else if (WRITABLE)
    begin
      if (write_en)
      begin
        value <= write_data;
      end
    end
    else
    begin
      value <= value | event_in;
    end
  end

endmodule

/* File: pcrb_bank.sv */
module pcrb_bank
  import pcrb_pkg::*;
#(
  parameter int ADDR_W = 10
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire pcrb_events_t events,
  output logic [7:0] page_select,
  output logic [NUM_REGS-1:0][7:0] reg_values,
  output logic irq
);

  // ****************************************************************
  // Address decode.
  // ****************************************************************
  function automatic pcrb_decode_t decode_index(
    input logic [7:0] page,
    input logic [7:0] index
  );
    pcrb_decode_t d;
    d.kind = KIND_NONE;
    d.slot = 5'h00;
    if (index == IDX_PAGE)
    begin
      d.kind = KIND_PAGE;
    end
    else if (index == IDX_SRST)
    begin
      d.kind = KIND_SRST;
    end
    else if (page == PAGE_ZERO)
    begin
      case (index)
        IDX_IRQ_STATUS: d.kind = KIND_IRQ_STATUS;
        IDX_IRQ_CLEAR: d.kind = KIND_IRQ_CLEAR;
        IDX_IRQ_ENABLE: d.kind = KIND_IRQ_ENABLE;
        default: d.kind = KIND_NONE;
      endcase
      for (int i = 0; i < NUM_REGS; i++)
      begin
        if (CELL_INDEX[i] == index)
        begin
          d.kind = KIND_CELL;
          d.slot = 5'(i);
        end
      end
    end
    return d;
  endfunction

  // ****************************************************************
  // Write channels.
  // ****************************************************************
  logic aw_held;
  logic [7:0] aw_index;
  logic w_held;
  logic [7:0] w_byte;
  logic w_lane;
  logic wr_fire;
  logic wr_lane;
  pcrb_decode_t wr_dec;
  logic soft_reset;
  logic [7:0] irq_status;
  logic [7:0] irq_enable;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_lane = wr_fire && w_lane;
  assign wr_dec = decode_index(page_select, aw_index);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      aw_held <= 1'b0;
      aw_index <= 8'h00;
    end
    else if (s_axi_awvalid && !aw_held)
    begin
      aw_held <= 1'b1;
      aw_index <= s_axi_awaddr[IDX_MSB:IDX_LSB];
    end
    else if (wr_fire)
    begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
    end
    else if (s_axi_wvalid && !w_held)
    begin
      w_held <= 1'b1;
      w_byte <= s_axi_wdata[7:0];
      w_lane <= s_axi_wstrb[0];
    end
    else if (wr_fire)
    begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_dec.kind == KIND_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Page select and software reset.
  // ****************************************************************
  // one-cycle reset pulse
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      soft_reset <= 1'b0;
    end
    else
    begin
      soft_reset <= wr_lane && wr_dec.kind == KIND_SRST && w_byte[SRST_BIT];
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      page_select <= PAGE_RESET;
    end
    else if (soft_reset)
    begin
      page_select <= PAGE_RESET;
    end
    else if (wr_lane && wr_dec.kind == KIND_PAGE)
    begin
      page_select <= w_byte;
    end
  end

  // ****************************************************************
  // Page zero register cells.
  // ****************************************************************
  logic [NUM_EVENTS-1:0][7:0] ro_events;
  assign ro_events = events;

  for (genvar g = 0; g < NUM_REGS; g++)
  begin : gen_cell
    localparam bit WR = (CELL_EVENT[g] < 0);
    logic [7:0] cell_event;
    if (WR)
    begin : gen_wr
      assign cell_event = 8'h00;
    end
    else
    begin : gen_ro
      assign cell_event = ro_events[CELL_EVENT[g]];
    end
    pcrb_reg_cell #(
      .RESET_VALUE(CELL_RESET[g]),
      .WRITABLE(WR)
    ) u_cell (
      .clk(clk),
      .reset(reset),
      .soft_reset(soft_reset),
      .write_en(wr_lane && wr_dec.kind == KIND_CELL && wr_dec.slot == 5'(g)),
      .write_data(w_byte),
      .event_in(cell_event),
      .value(reg_values[g])
    );
  end

  // ****************************************************************
  // Interrupt status, clear and enable.
  // ****************************************************************
  logic [7:0] ev_any;
  logic [7:0] irq_clear;

  always_comb
  begin
    for (int i = 0; i < NUM_EVENTS; i++)
    begin
      ev_any[i] = |ro_events[i];
    end
  end

  assign irq_clear = (wr_lane && wr_dec.kind == KIND_IRQ_CLEAR) ? w_byte : 8'h00;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      irq_status <= IRQ_RESET;
    end
    else if (soft_reset)
    begin
      irq_status <= IRQ_RESET;
    end
    else
    begin
      irq_status <= (irq_status & ~irq_clear) | ev_any;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      irq_enable <= IRQ_RESET;
    end
    else if (soft_reset)
    begin
      irq_enable <= IRQ_RESET;
    end
    else if (wr_lane && wr_dec.kind == KIND_IRQ_ENABLE)
    begin
      irq_enable <= w_byte;
    end
  end

  assign irq = |(irq_status & irq_enable);

  // ****************************************************************
  // Read channel.
  // ****************************************************************
  pcrb_decode_t rd_dec;
  logic ar_fire;
  logic [7:0] rd_byte;

  assign s_axi_arready = !s_axi_rvalid;
  assign ar_fire = s_axi_arvalid && !s_axi_rvalid;
  assign rd_dec = decode_index(page_select, s_axi_araddr[IDX_MSB:IDX_LSB]);

  always_comb
  begin
    case (rd_dec.kind)
      KIND_PAGE: rd_byte = page_select;
      // reset bit and upper bits read zero
      KIND_SRST: rd_byte = 8'h00;
      KIND_CELL: rd_byte = reg_values[rd_dec.slot];
      KIND_IRQ_STATUS: rd_byte = irq_status;
      KIND_IRQ_ENABLE: rd_byte = irq_enable;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (ar_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= (rd_dec.kind == KIND_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  a_srst_request: assert property (
    @(posedge clk) disable iff (reset)
    (wr_lane && wr_dec.kind == KIND_SRST && w_byte[SRST_BIT]) |=> soft_reset ##1 !soft_reset)
    else $error("Software reset request not carried out.");
  a_srst_zero: assert property (
    @(posedge clk) disable iff (reset)
    (wr_fire && wr_dec.kind == KIND_SRST && !(w_lane && w_byte[SRST_BIT])) |=> !soft_reset)
    else $error("Software reset raised without a one written.");
  a_srst_readback: assert property (
    @(posedge clk) disable iff (reset)
    (ar_fire && rd_dec.kind == KIND_SRST) |=> s_axi_rvalid && s_axi_rdata == 32'h00000000)
    else $error("Software reset register did not read zero.");
  a_page_write: assert property (
    @(posedge clk) disable iff (reset)
    (wr_lane && wr_dec.kind == KIND_PAGE) |=> page_select == $past(w_byte))
    else $error("Page select did not take the written code.");
  a_page_reach: assert property (
    @(posedge clk) disable iff (reset)
    (ar_fire && s_axi_araddr[IDX_MSB:IDX_LSB] == IDX_PAGE)
      |=> s_axi_rresp == RESP_OKAY && s_axi_rdata[7:0] == $past(page_select))
    else $error("Page select not readable on this page.");
  a_page_split: assert property (
    @(posedge clk) disable iff (reset)
    (ar_fire && page_select != PAGE_ZERO && s_axi_araddr[IDX_MSB:IDX_LSB] > IDX_SRST)
      |=> s_axi_rresp == RESP_SLVERR)
    else $error("Page zero register reached from another page.");
  a_page_default: assert property (
    @(posedge clk) disable iff (reset)
    soft_reset |=> page_select == PAGE_RESET)
    else $error("Page select not back at page zero.");
  a_chan_default: assert property (
    @(posedge clk) disable iff (reset)
    soft_reset |=> reg_values[SLOT_CHANNEL_ENABLES] == CELL_RESET[SLOT_CHANNEL_ENABLES])
    else $error("Channel enables not at default.");
  a_conv_default: assert property (
    @(posedge clk) disable iff (reset)
    soft_reset |=> reg_values[SLOT_CH1A_0] == CELL_RESET[SLOT_CH1A_0]
      && reg_values[SLOT_CH1A_1] == CELL_RESET[SLOT_CH1A_1])
    else $error("Converter configuration not at default.");
  a_out_default: assert property (
    @(posedge clk) disable iff (reset)
    soft_reset |=> reg_values[SLOT_OUT1_0] == CELL_RESET[SLOT_OUT1_0])
    else $error("Output configuration not at default.");
  a_state_default: assert property (
    @(posedge clk) disable iff (reset)
    soft_reset |=> reg_values[SLOT_STATE0] == CELL_RESET[SLOT_STATE0]
      && reg_values[SLOT_STATE1] == CELL_RESET[SLOT_STATE1])
    else $error("Device state registers not at default.");
  a_fault_default: assert property (
    @(posedge clk) disable iff (reset)
    soft_reset |=> reg_values[SLOT_FAULT0] == CELL_RESET[SLOT_FAULT0]
      && reg_values[SLOT_RATIO3] == CELL_RESET[SLOT_RATIO3])
    else $error("Clock status registers not cleared.");
  a_sproc_default: assert property (
    @(posedge clk) disable iff (reset)
    soft_reset |=> reg_values[SLOT_SPROC] == CELL_RESET[SLOT_SPROC])
    else $error("Signal processing configuration not at default.");

endmodule

/* File: pcrb_host.sv */
// ****
// Host controller model on the register bus.
// ****
module pcrb_host
(
  input wire logic clk,
  output logic [9:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [9:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  int hangs = 0;

  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  // Released address and data lines show the inverse of their last value; the write strobe keeps its value.
  task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic s,
    output logic [1:0] r);
    logic a;
    logic w;
    int n;
    a = 1'b1;
    w = 1'b1;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= {3'h0, s};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (a && s_axi_awready === 1'b1)
      begin
        a = 1'b0;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~s_axi_awaddr;
      end
      if (w && s_axi_wready === 1'b1)
      begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~s_axi_wdata;
      end
    end
    while ((a || w) && n < 100);
    repeat ($urandom_range(2)) @(posedge clk);
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (s_axi_bvalid !== 1'b1 && n < 200);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 200 || a || w)
      hangs++;
  endtask

  task automatic rd(input logic [7:0] i, output logic [31:0] d,
    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (s_axi_arready !== 1'b1 && n < 100);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~s_axi_araddr;
    repeat ($urandom_range(2)) @(posedge clk);
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (s_axi_rvalid !== 1'b1 && n < 200);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 200)
      hangs++;
  endtask
endmodule

/* File: tb_top.sv */
// ****
// Register bank bench.
// ****
module tb_top
  import pcrb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [9:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  logic [7:0] page_select;
  logic [NUM_REGS-1:0][7:0] reg_values;
  logic [7:0] exp_reg [NUM_REGS];
  pcrb_events_t events = '0;
  int error_cnt = 0;
  int n_tests = 0;

  pcrb_bank #(
    .ADDR_W(10)
  ) u_dut (
    .clk(clk),
    .reset(reset),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .events(events),
    .page_select(page_select),
    .reg_values(reg_values),
    .irq(irq)
  );

  pcrb_host u_host (
    .clk(clk),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );

  initial
  begin
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t resp got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic hang_chk();
    if (u_host.hangs > 0)
    begin
      error_cnt++;
      summarize();
    end
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic s = 1'b1);
    u_host.wr(i, d, s, resp);
    hang_chk();
  endtask

  task automatic rd(input logic [7:0] i);
    u_host.rd(i, rdv, resp);
    hang_chk();
  endtask

  task automatic rchk(input logic [7:0] i, input logic [7:0] e);
    rd(i);
    chk(rdv, {24'h000000, e});
    chk_resp(resp, RESP_OKAY);
  endtask

  // Soft reset, then the fixed two edges until defaults are in place.
  task automatic srst();
    wr(IDX_SRST, 8'h01);
    repeat (2) @(posedge clk);
    for (int i = 0; i < NUM_REGS; i++)
      exp_reg[i] = CELL_RESET[i];
  endtask

  task automatic rd_all();
    for (int i = 0; i < NUM_REGS; i++)
    begin
      rchk(CELL_INDEX[i], exp_reg[i]);
      chk(32'(reg_values[i]), 32'(exp_reg[i]));
    end
  endtask

  task automatic chk_irq(input logic e);
    @(negedge clk);
    chk(32'(irq), 32'(e));
  endtask

  // Expected status: one bit for each event byte that saw any event.
  function automatic logic [7:0] ev_status(input pcrb_events_t e);
    logic [NUM_EVENTS-1:0][7:0] b;
    logic [7:0] s;
    b = e;
    s = 8'h00;
    for (int i = 0; i < NUM_EVENTS; i++)
      s[i] = |b[i];
    return s;
  endfunction

  initial
  begin
    logic [7:0] v;
    logic [7:0] p;
    pcrb_events_t ev;
    void'($urandom(32'h5f2c3a86));
    for (int i = 0; i < NUM_REGS; i++)
      exp_reg[i] = CELL_RESET[i];
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    chk(32'(page_select), 32'h0);
    rd_all();
    rchk(8'h3C, 8'h00);
    rchk(8'h76, 8'hCC);
    rchk(8'h67, 8'hC9);
    rchk(8'h71, 8'h80);
    rchk(8'h6D, 8'h20);
    rchk(8'h7A, 8'h80);
    rchk(8'h79, 8'h00);
    rchk(8'h73, 8'h18);
    $display("test defaults done");
    for (int i = 0; i < NUM_REGS; i++)
    begin
      v = 8'($urandom);
      wr(CELL_INDEX[i], v);
      chk_resp(resp, RESP_OKAY);
      if (CELL_EVENT[i] < 0)
        exp_reg[i] = v;
    end
    wr(8'h76, ~exp_reg[SLOT_CHANNEL_ENABLES], 1'b0);
    rd_all();
    wr(IDX_SRST, 8'h00);
    rd_all();
    rchk(IDX_SRST, 8'h00);
    srst();
    rchk(IDX_SRST, 8'h00);
    rd_all();
    $display("test soft_reset done");
    for (int k = 0; k < 2; k++)
    begin
      p = (k == 0) ? 8'hFF : 8'($urandom_range(254, 1));
      wr(IDX_PAGE, p);
      chk(32'(page_select), 32'(p));
      rchk(IDX_PAGE, p);
      rchk(IDX_SRST, 8'h00);
      rd(8'h76);
      chk_resp(resp, RESP_SLVERR);
      chk(rdv, 32'h0);
      wr(8'h76, 8'h00);
      chk_resp(resp, RESP_SLVERR);
      if (k == 0)
        wr(IDX_PAGE, PAGE_ZERO);
      else
        srst();
      chk(32'(page_select), 32'h0);
    end
    rchk(8'h76, exp_reg[SLOT_CHANNEL_ENABLES]);
    rd(8'h02);
    chk_resp(resp, RESP_SLVERR);
    wr(8'h44, 8'h5A);
    chk_resp(resp, RESP_SLVERR);
    $display("test paging done");
    v = 8'($urandom_range(255, 1));
    ev = '0;
    ev.clock_fault[0] = v;
    ev.ratio_detect[3] = 8'h80;
    @(posedge clk);
    events <= ev;
    @(posedge clk);
    events <= '0;
    rchk(8'h3C, v);
    rchk(8'h41, 8'h80);
    rchk(IDX_IRQ_STATUS, ev_status(ev));
    chk_irq(1'b0);
    wr(IDX_IRQ_ENABLE, 8'h20);
    chk_irq(1'b1);
    wr(IDX_IRQ_ENABLE, 8'h00);
    chk_irq(1'b0);
    wr(IDX_IRQ_ENABLE, 8'h21);
    wr(IDX_IRQ_CLEAR, 8'h20);
    chk_irq(1'b1);
    rchk(IDX_IRQ_STATUS, 8'h01);
    wr(IDX_IRQ_CLEAR, 8'h01);
    chk_irq(1'b0);
    srst();
    rchk(8'h3C, 8'h00);
    rchk(IDX_IRQ_ENABLE, 8'h00);
    $display("test events done");
    summarize();
  end
endmodule
